// *** core/adccfg_pkg.sv ***
package adccfg_pkg;

  // Bank geometry.
  localparam int REG_COUNT = 16;
  localparam int BANK_COUNT = 8;
  localparam int RAM_BYTES = REG_COUNT * BANK_COUNT;

  // Register offsets within one bank.
  localparam logic [3:0] REG_DEVICE_CONFIG = 4'h0;
  localparam logic [3:0] REG_INPUT_SELECT = 4'h1;
  localparam logic [3:0] REG_ANALOG_CONTROL = 4'h2;
  localparam logic [3:0] REG_CURRENT_SOURCE_1_CODE = 4'h3;
  localparam logic [3:0] REG_CURRENT_SOURCE_2_CODE = 4'h4;
  localparam logic [3:0] REG_OFFSET_TRIM = 4'h5;
  localparam logic [3:0] REG_PIN_VALUE = 4'h6;
  localparam logic [3:0] REG_PIN_ORIENTATION = 4'h7;
  localparam logic [3:0] REG_RATE_DIVIDER_LOW = 4'h8;
  localparam logic [3:0] REG_MODE_RATE_DIVIDER_HIGH = 4'h9;
  localparam logic [3:0] REG_OFFSET_CAL_0 = 4'hA;
  localparam logic [3:0] REG_OFFSET_CAL_1 = 4'hB;
  localparam logic [3:0] REG_OFFSET_CAL_2 = 4'hC;
  localparam logic [3:0] REG_GAIN_CAL_0 = 4'hD;
  localparam logic [3:0] REG_GAIN_CAL_1 = 4'hE;
  localparam logic [3:0] REG_GAIN_CAL_2 = 4'hF;

  // Reset values; the device_config low bits sit under the factory code.
  localparam logic [4:0] RST_DEVICE_CONFIG_LOW = 5'h0E;
  localparam logic [7:0] RST_INPUT_SELECT = 8'h01;
  localparam logic [7:0] RST_PIN_ORIENTATION = 8'hFF;
  localparam logic [7:0] RST_RATE_DIVIDER_LOW = 8'h80;
  localparam logic [7:0] RST_MODE_RATE_DIVIDER_HIGH = 8'h07;
  localparam logic [7:0] RST_OTHER = 8'h00;

  // Field positions.
  localparam int CFG_BIT_ORDER = 0;
  localparam int CFG_BUF_EN = 1;
  localparam int CFG_REF_LEVEL = 2;
  localparam int CFG_REF_EN = 3;
  localparam int CFG_SPEED = 4;
  localparam int CFG_CODE_LSB = 5;
  localparam int MODE_READY_BIT = 7;

  // Serial opcodes: upper nibble selects, lower nibble is index, bank or a fixed code.
  localparam logic [3:0] OP_READ_DATA = 4'h0;
  localparam logic [3:0] OP_READ_DATA_LO = 4'h1;
  localparam logic [3:0] OP_READ_REG = 4'h1;
  localparam logic [3:0] OP_READ_RAM = 4'h2;
  localparam logic [3:0] OP_SET_POINTER = 4'h3;
  localparam logic [3:0] OP_SAVE_BANK = 4'h4;
  localparam logic [3:0] OP_WRITE_REG = 4'h5;
  localparam logic [3:0] OP_WRITE_RAM = 4'h6;
  localparam logic [3:0] OP_CHECKSUM = 4'h9;
  localparam logic [3:0] OP_LOAD_BANK = 4'hC;
  localparam logic [3:0] OP_SYNC = 4'hF;
  localparam logic [3:0] OP_SYNC_LO = 4'hC;

  // Bytes that follow the first byte of a conversion result read.
  localparam logic [1:0] DATA_TAIL_BYTES = 2'h2;

  typedef enum logic [1:0] {
    ST_CMD,
    ST_PTR,
    ST_WRITE,
    ST_READ
  } adccfg_state_t;

endpackage : adccfg_pkg

// *** core/adccfg_serial_bank.sv ***
// Behaviour
// - Serial clock shifts input and output bits back to back, no pauses.
// - Clock-sense input high: active-high serial clock; low: active-low.
// - Ready flag goes low when a new conversion result is available.
// - Ready flag returns high once a conversion data read completes.
// - Ready flag rises before the result register updates; host waits then.
// - Sync is possible from the sync pin or a serial sync command.
// - Sync pin falling edge resets filter; modulator held reset while low.
// - After sync pin returns high, conversion restarts on next clock edge.
// - Sixteen configuration registers are directly read and written.
// - Single register and RAM accesses move bytes; copies move banks.
// - RAM has eight independent sixteen-byte banks, usable from power-up.
// - RAM pointer auto-increments across banks and wraps to bank zero.
// - Linear address upper three bits are bank, lower nibble register offset.
// - Checksum command returns a sum over a RAM bank for checking.
// - Speed bit picks modulator divide by 128 when clear, 256 when set.
// - Reference enable bit switches the on-chip reference on or off.
// - Reference level bit picks 1.25V when clear, 2.5V when set.
// - Buffer bit enables the analog input buffer when set.
// - Bit-order bit affects outgoing bytes only; input always MSB first.
// - Top three config bits hold a factory code software cannot change.
`timescale 1ns/1ns
`default_nettype none

module adccfg_serial_bank #(
  parameter logic [2:0] FACTORY_CODE = 3'h5 // Arbitrary value.
) (
  input wire logic mclk, // System clock, 100 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic sclk, // Serial clock pin.
  input wire logic din, // Serial data in pin.
  input wire logic cs_n, // Chip select pin, active low.
  input wire logic clock_sense_select, // Static serial clock sense pin.
  input wire logic conversion_sync_pin_n, // Sync pin, active low.
  input wire logic conv_valid, // Filter result strobe, one cycle.
  input wire logic [23:0] conv_result, // Filter result word.
  output logic dout, // Serial data out pin.
  output logic conversion_ready_flag_n, // Result ready, active low.
  output logic filter_reset, // Filter counter reset pulse.
  output logic modulator_reset, // Modulator hold level.
  output logic conv_restart, // Conversion restart pulse.
  output logic mod_clk_div256, // Modulator divide select.
  output logic vref_enable, // On-chip reference enable.
  output logic vref_level_select, // Reference level select.
  output logic input_buffer_enable, // Analog input buffer enable.
  output logic [2:0] pos_channel, // Positive input channel.
  output logic pos_common, // Positive input is common input.
  output logic pos_temp, // Positive input is temperature diode.
  output logic [2:0] negative_input_choice, // Negative input channel.
  output logic neg_common, // Negative input is common input.
  output logic neg_temp, // Negative input is temperature diode.
  output logic [15:0][7:0] config_bank // Live register bank.
);
  import adccfg_pkg::*;

  typedef struct packed {
    adccfg_state_t st;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_p;
    logic din_s1;
    logic din_s2;
    logic cs_s1;
    logic cs_s2;
    logic sense_s1;
    logic sense_s2;
    logic sync_s1;
    logic sync_s2;
    logic sync_p;
    logic [2:0] bitcnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] cmd;
    logic [1:0] nleft;
    logic dout;
    logic [6:0] ptr;
    logic [15:0][7:0] regs;
    logic [127:0][7:0] ram;
    logic [23:0] pend;
    logic [23:0] data;
    logic upd_pend;
    logic ready_n;
    logic filt_rst;
    logic mod_rst;
    logic restart;
    logic [4:0] pos_dec;
    logic [4:0] neg_dec;
  } adccfg_state_rec_t;

  adccfg_state_rec_t s_q;
  adccfg_state_rec_t s_d;

  // Outgoing bytes may be reversed; incoming bytes never are.
  function automatic logic [7:0] out_order(input logic lsb_first,
                                           input logic [7:0] b);
    logic [7:0] r;
    r = b;
    if (lsb_first) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = b[7 - i];
      end
    end
    return r;
  endfunction : out_order

  // Register readback; the mode register shows the live ready level.
  function automatic logic [7:0] reg_read(input logic [15:0][7:0] regs,
                                          input logic ready_n,
                                          input logic [3:0] idx);
    logic [7:0] r;
    r = regs[idx];
    if (idx == REG_MODE_RATE_DIVIDER_HIGH) begin
      r[MODE_READY_BIT] = ready_n;
    end
    return r;
  endfunction : reg_read

  // Write filter: factory code and the ready copy are not writable.
  function automatic logic [7:0] reg_write(input logic [3:0] idx,
                                           input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (idx == REG_DEVICE_CONFIG) begin
      r[7:CFG_CODE_LSB] = FACTORY_CODE;
    end
    if (idx == REG_MODE_RATE_DIVIDER_HIGH) begin
      r[MODE_READY_BIT] = 1'b0;
    end
    return r;
  endfunction : reg_write

  // Eight-bit sum of one RAM bank.
  function automatic logic [7:0] bank_sum(input logic [127:0][7:0] ram,
                                          input logic [2:0] bank);
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < REG_COUNT; i++) begin
      acc = 8'(acc + ram[{bank, 4'(i)}]);
    end
    return acc;
  endfunction : bank_sum

  // Input nibble decode: {temperature, common, channel}.
  function automatic logic [4:0] input_decode(input logic [3:0] nib);
    logic temp;
    temp = (nib == 4'hF);
    return {temp, nib[3] & ~temp, nib[2:0]};
  endfunction : input_decode

  logic act_now;
  logic act_prev;
  logic lead;
  logic trail;
  logic [7:0] rxb;
  logic lsbf;

  // Pins are synchronised, then serial edges are found on the system clock.
  // This limits the serial clock to well under a quarter of mclk.
  always_comb begin
    s_d = s_q;
    s_d.sclk_s1 = sclk;
    s_d.sclk_s2 = s_q.sclk_s1;
    s_d.sclk_p = s_q.sclk_s2;
    s_d.din_s1 = din;
    s_d.din_s2 = s_q.din_s1;
    s_d.cs_s1 = cs_n;
    s_d.cs_s2 = s_q.cs_s1;
    s_d.sense_s1 = clock_sense_select;
    s_d.sense_s2 = s_q.sense_s1;
    s_d.sync_s1 = conversion_sync_pin_n;
    s_d.sync_s2 = s_q.sync_s1;
    s_d.sync_p = s_q.sync_s2;
    s_d.filt_rst = 1'b0;
    s_d.restart = 1'b0;
    lsbf = s_q.regs[REG_DEVICE_CONFIG][CFG_BIT_ORDER];
    act_now = (s_q.sclk_s2 == s_q.sense_s2);
    act_prev = (s_q.sclk_p == s_q.sense_s2);
    lead = act_now & ~act_prev;
    trail = ~act_now & act_prev;
    rxb = {s_q.rx[6:0], s_q.din_s2};

    if (s_q.cs_s2) begin
      // Deselect aborts any transfer and realigns to a command byte.
      s_d.st = ST_CMD;
      s_d.bitcnt = 3'h0;
    end else begin
      if (lead) begin
        s_d.dout = s_q.tx[7];
        s_d.tx = {s_q.tx[6:0], 1'b0};
      end
      if (trail) begin
        s_d.rx = rxb;
        s_d.bitcnt = 3'(s_q.bitcnt + 3'h1);
        if (s_q.bitcnt == 3'h7) begin
          unique case (s_q.st)
            ST_CMD: begin
              s_d.cmd = rxb;
              s_d.nleft = 2'h0;
              case (rxb[7:4])
                OP_READ_DATA: begin
                  if (rxb[3:0] == OP_READ_DATA_LO) begin
                    s_d.tx = out_order(lsbf, s_q.data[23:16]);
                    s_d.nleft = DATA_TAIL_BYTES;
                    s_d.st = ST_READ;
                  end
                end
                OP_READ_REG: begin
                  s_d.tx = out_order(lsbf,
                    reg_read(s_q.regs, s_q.ready_n, rxb[3:0]));
                  s_d.st = ST_READ;
                end
                OP_READ_RAM: begin
                  s_d.tx = out_order(lsbf, s_q.ram[s_q.ptr]);
                  s_d.ptr = 7'(s_q.ptr + 7'h01);
                  s_d.st = ST_READ;
                end
                OP_SET_POINTER: s_d.st = ST_PTR;
                OP_WRITE_REG: s_d.st = ST_WRITE;
                OP_WRITE_RAM: s_d.st = ST_WRITE;
                OP_SAVE_BANK: begin
                  for (int i = 0; i < REG_COUNT; i++) begin
                    s_d.ram[{rxb[2:0], 4'(i)}] =
                      reg_read(s_q.regs, s_q.ready_n, 4'(i));
                  end
                end
                OP_LOAD_BANK: begin
                  for (int i = 0; i < REG_COUNT; i++) begin
                    s_d.regs[i] = reg_write(4'(i),
                      s_q.ram[{rxb[2:0], 4'(i)}]);
                  end
                end
                OP_CHECKSUM: begin
                  s_d.tx = out_order(lsbf, bank_sum(s_q.ram, rxb[2:0]));
                  s_d.st = ST_READ;
                end
                OP_SYNC: begin
                  if (rxb[3:0] == OP_SYNC_LO) begin
                    s_d.filt_rst = 1'b1;
                    s_d.restart = 1'b1;
                  end
                end
                default: ;
              endcase
            end
            ST_PTR: begin
              // Bits 6:4 are the bank, lower nibble the offset; bit 7 is dropped.
              s_d.ptr = rxb[6:0];
              s_d.st = ST_CMD;
            end
            ST_WRITE: begin
              if (s_q.cmd[7:4] == OP_WRITE_REG) begin
                s_d.regs[s_q.cmd[3:0]] = reg_write(s_q.cmd[3:0], rxb);
              end else begin
                s_d.ram[s_q.ptr] = rxb;
                s_d.ptr = 7'(s_q.ptr + 7'h01);
              end
              s_d.st = ST_CMD;
            end
            ST_READ: begin
              if (s_q.nleft == 2'h0) begin
                s_d.st = ST_CMD;
                if (s_q.cmd == {OP_READ_DATA, OP_READ_DATA_LO}) begin
                  s_d.ready_n = 1'b1;
                end
              end else begin
                s_d.nleft = 2'(s_q.nleft - 2'h1);
                s_d.tx = out_order(lsbf, (s_q.nleft == DATA_TAIL_BYTES) ?
                  s_q.data[15:8] : s_q.data[7:0]);
              end
            end
          endcase
        end
      end
    end

    // Ready rises a cycle ahead of the result update, then falls with it.
    // A new result outranks a read completing in the same cycle.
    if (s_q.upd_pend) begin
      s_d.data = s_q.pend;
      s_d.upd_pend = 1'b0;
      s_d.ready_n = 1'b0;
    end
    if (conv_valid) begin
      s_d.pend = conv_result;
      s_d.upd_pend = 1'b1;
      s_d.ready_n = 1'b1;
    end

    // Sync pin: edge resets the filter, low level holds the modulator.
    s_d.mod_rst = ~s_q.sync_s2;
    if (s_q.sync_p & ~s_q.sync_s2) begin
      s_d.filt_rst = 1'b1;
    end
    if (~s_q.sync_p & s_q.sync_s2) begin
      s_d.restart = 1'b1;
    end

    s_d.pos_dec = input_decode(s_d.regs[REG_INPUT_SELECT][7:4]);
    s_d.neg_dec = input_decode(s_d.regs[REG_INPUT_SELECT][3:0]);
  end

  // State register; RAM clears at reset so it is usable from power-up.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.st <= ST_CMD;
      s_q.cs_s1 <= 1'b1;
      s_q.cs_s2 <= 1'b1;
      s_q.sync_s1 <= 1'b1;
      s_q.sync_s2 <= 1'b1;
      s_q.sync_p <= 1'b1;
      s_q.ready_n <= 1'b1;
      s_q.regs[REG_DEVICE_CONFIG] <= {FACTORY_CODE, RST_DEVICE_CONFIG_LOW};
      s_q.regs[REG_INPUT_SELECT] <= RST_INPUT_SELECT;
      s_q.regs[REG_ANALOG_CONTROL] <= RST_OTHER;
      s_q.regs[REG_PIN_ORIENTATION] <= RST_PIN_ORIENTATION;
      s_q.regs[REG_RATE_DIVIDER_LOW] <= RST_RATE_DIVIDER_LOW;
      s_q.regs[REG_MODE_RATE_DIVIDER_HIGH] <= RST_MODE_RATE_DIVIDER_HIGH;
      s_q.pos_dec <= 5'h00;
      s_q.neg_dec <= 5'h01;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a field of the state register.
  assign dout = s_q.dout;
  assign conversion_ready_flag_n = s_q.ready_n;
  assign filter_reset = s_q.filt_rst;
  assign modulator_reset = s_q.mod_rst;
  assign conv_restart = s_q.restart;
  assign mod_clk_div256 = s_q.regs[REG_DEVICE_CONFIG][CFG_SPEED];
  assign vref_enable = s_q.regs[REG_DEVICE_CONFIG][CFG_REF_EN];
  assign vref_level_select =
    s_q.regs[REG_DEVICE_CONFIG][CFG_REF_LEVEL];
  assign input_buffer_enable =
    s_q.regs[REG_DEVICE_CONFIG][CFG_BUF_EN];
  assign pos_channel = s_q.pos_dec[2:0];
  assign pos_common = s_q.pos_dec[3];
  assign pos_temp = s_q.pos_dec[4];
  assign negative_input_choice = s_q.neg_dec[2:0];
  assign neg_common = s_q.neg_dec[3];
  assign neg_temp = s_q.neg_dec[4];
  assign config_bank = s_q.regs;

endmodule : adccfg_serial_bank

`default_nettype wire

// *** verification/adccfg_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module adccfg_host_model (
  input wire logic mclk, // Clock.
  input wire logic clock_sense_select, // Clock sense.
  input wire logic dout, // Device data out.
  output logic sclk, // Serial clock.
  output logic din, // Serial data in.
  output logic cs_n // Select, low.
);
  // Six clocks per half period stays above the four-clock minimum.
  localparam int HALF = 6;

  // Idle bus at time zero.
  initial begin
    sclk = 1'b0;
    din = 1'b0;
    cs_n = 1'b1;
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
  endtask : wait_n

  // Clock parks at its inactive level before select drops.
  task automatic begin_frame();
    @(posedge mclk);
    sclk <= ~clock_sense_select;
    wait_n(HALF);
    cs_n <= 1'b0;
    wait_n(HALF);
  endtask : begin_frame

  // A released data line flips so no stale bit can be mistaken.
  task automatic end_frame();
    wait_n(HALF);
    cs_n <= 1'b1;
    din <= ~din;
    wait_n(HALF);
  endtask : end_frame

  // Bits go out back to back; the reply is taken before the trailing edge.
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      din <= tx[i];
      sclk <= clock_sense_select;
      wait_n(HALF);
      rx[i] = dout;
      sclk <= ~clock_sense_select;
      wait_n(HALF);
    end
  endtask : byte_io
endmodule : adccfg_host_model

`default_nettype wire

// *** verification/adccfg_serial_bank_sva.sv ***
`timescale 1ns/1ns
`default_nettype none

module adccfg_serial_bank_sva #(
  parameter logic [2:0] FACTORY_CODE = 3'h0 // Arbitrary value.
) (
  input wire logic mclk, // Clock.
  input wire logic resetn, // Reset, low.
  input wire logic conversion_sync_pin_n, // Sync pin.
  input wire logic conv_valid, // Result strobe.
  input wire logic conversion_ready_flag_n, // Ready, low.
  input wire logic filter_reset, // Filter reset.
  input wire logic modulator_reset, // Modulator hold.
  input wire logic conv_restart, // Restart.
  input wire logic mod_clk_div256, // Speed.
  input wire logic vref_enable, // Ref on.
  input wire logic vref_level_select, // Ref level.
  input wire logic input_buffer_enable, // Buffer.
  input wire logic [2:0] pos_channel, // Pos channel.
  input wire logic pos_common, // Pos common.
  input wire logic pos_temp, // Pos diode.
  input wire logic [2:0] negative_input_choice, // Neg channel.
  input wire logic neg_common, // Neg common.
  input wire logic neg_temp, // Neg diode.
  input wire logic [15:0][7:0] config_bank // Registers.
);
  // Single clock domain; reset disables every check.
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // Sync timing allows for the input synchronisers.
  a_sync_fall: assert property (
    $fell(conversion_sync_pin_n) |-> ##[1:6] filter_reset)
    else $error("No filter reset after sync fall.");
  a_filter_pulse: assert property (
    filter_reset |=> !filter_reset)
    else $error("Filter reset longer than a cycle.");
  a_mod_held: assert property (
    (!conversion_sync_pin_n) [*6] |-> modulator_reset)
    else $error("Modulator not held while sync low.");
  a_mod_free: assert property (
    conversion_sync_pin_n [*6] |-> !modulator_reset)
    else $error("Modulator held while sync high.");
  a_sync_restart: assert property (
    $rose(conversion_sync_pin_n) |-> ##[1:6] conv_restart)
    else $error("No restart after sync rise.");
  a_restart_free: assert property (
    conv_restart |=> !modulator_reset)
    else $error("Restart with modulator held.");
  // Ready must rise for a cycle before the new result lands.
  a_ready_update: assert property (
    conv_valid |=> conversion_ready_flag_n ##1 !conversion_ready_flag_n)
    else $error("Ready flag sequence wrong on new result.");
  a_cfg_out: assert property (
    $stable(config_bank[0]) |-> {mod_clk_div256, vref_enable,
    vref_level_select, input_buffer_enable} == config_bank[0][4:1])
    else $error("Config outputs differ from register.");
  a_code_fixed: assert property (
    config_bank[0][7:5] == FACTORY_CODE)
    else $error("Factory code changed.");
  a_pos_decode: assert property (
    $stable(config_bank[1]) |-> pos_channel == config_bank[1][6:4] &&
    pos_temp == (config_bank[1][7:4] == 4'hF) &&
    pos_common == (config_bank[1][7] && config_bank[1][7:4] != 4'hF))
    else $error("Positive input decode wrong.");
  a_neg_decode: assert property (
    $stable(config_bank[1]) |->
    negative_input_choice == config_bank[1][2:0] &&
    neg_temp == (config_bank[1][3:0] == 4'hF) &&
    neg_common == (config_bank[1][3] && config_bank[1][3:0] != 4'hF))
    else $error("Negative input decode wrong.");
endmodule : adccfg_serial_bank_sva

bind adccfg_serial_bank adccfg_serial_bank_sva #(
  .FACTORY_CODE(FACTORY_CODE)
) adccfg_serial_bank_sva_inst (
  .mclk, .resetn, .conversion_sync_pin_n, .conv_valid,
  .conversion_ready_flag_n, .filter_reset, .modulator_reset,
  .conv_restart, .mod_clk_div256, .vref_enable, .vref_level_select,
  .input_buffer_enable, .pos_channel, .pos_common, .pos_temp,
  .negative_input_choice, .neg_common, .neg_temp, .config_bank
);

`default_nettype wire

// *** verification/test_adc_config_bank_serial_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none

module test_adc_config_bank_serial_ctrl;
  import adccfg_pkg::*;
  localparam logic [2:0] FCODE = 3'h2; // Arbitrary value.
  logic mclk, resetn, sclk, din, cs_n, clock_sense_select, dout;
  logic conversion_sync_pin_n, conv_valid, conversion_ready_flag_n;
  logic filter_reset, modulator_reset, conv_restart, mod_clk_div256;
  logic vref_enable, vref_level_select, input_buffer_enable;
  logic pos_common, pos_temp, neg_common, neg_temp;
  logic [2:0] pos_channel, negative_input_choice;
  logic [23:0] conv_result;
  logic [15:0][7:0] config_bank;
  int errors, cmp_count, cycles, both_hits;

  adccfg_serial_bank #(.FACTORY_CODE(FCODE)) adccfg_serial_bank_inst (
    .mclk, .resetn, .sclk, .din, .cs_n, .clock_sense_select,
    .conversion_sync_pin_n, .conv_valid, .conv_result, .dout,
    .conversion_ready_flag_n, .filter_reset, .modulator_reset,
    .conv_restart, .mod_clk_div256, .vref_enable, .vref_level_select,
    .input_buffer_enable, .pos_channel, .pos_common, .pos_temp,
    .negative_input_choice, .neg_common, .neg_temp, .config_bank);
  adccfg_host_model adccfg_host_model_inst (
    .mclk, .clock_sense_select, .dout, .sclk, .din, .cs_n);

  always #5 mclk = ~mclk;

  // Hang guard; the command sync is the only source of a joint pulse.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    both_hits <= both_hits + int'(filter_reset && conv_restart);
    if (cycles == 80000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Sends n bytes, last byte in tx[7:0]; replies land in matching slots.
  task automatic seq(input int n, input logic [63:0] tx,
                     output logic [63:0] rx);
    logic [7:0] b;
    rx = '0;
    adccfg_host_model_inst.begin_frame();
    for (int k = n - 1; k >= 0; k--) begin
      adccfg_host_model_inst.byte_io(tx[8*k +: 8], b);
      rx[8*k +: 8] = b;
    end
    adccfg_host_model_inst.end_frame();
  endtask : seq

  function automatic logic [7:0] rst_val(input int i);
    case (i)
      0: return {FCODE, RST_DEVICE_CONFIG_LOW};
      1: return RST_INPUT_SELECT;
      7: return RST_PIN_ORIENTATION;
      8: return RST_RATE_DIVIDER_LOW;
      9: return {1'b1, RST_MODE_RATE_DIVIDER_HIGH[6:0]};
      default: return RST_OTHER;
    endcase
  endfunction : rst_val

  function automatic logic [4:0] dec(input logic [3:0] n);
    return {n[2:0], n[3] && n != 4'hF, n == 4'hF};
  endfunction : dec

  task automatic t_reset();
    logic [63:0] r;
    for (int i = 0; i < 16; i++) begin
      seq(2, {OP_READ_REG, 4'(i), 8'h00}, r);
      check("reset reg", r[7:0], rst_val(i));
    end
    seq(2, {OP_CHECKSUM, 4'h5, 8'h00}, r);
    check("blank bank sum", r[7:0], 8'h00);
  endtask : t_reset

  task automatic t_regs();
    logic [63:0] r;
    logic [7:0] cv [3] = '{8'hFE, 8'h00, 8'h14};
    logic [7:0] mv [3] = '{8'hF8, 8'h7F, 8'h35};
    for (int j = 0; j < 3; j++) begin
      seq(2, {OP_WRITE_REG, REG_DEVICE_CONFIG, cv[j]}, r);
      seq(2, {OP_READ_REG, REG_DEVICE_CONFIG, 8'h00}, r);
      check("device_config", r[7:0], {FCODE, cv[j][4:0]});
      check("config pins", {mod_clk_div256, vref_enable, vref_level_select,
            input_buffer_enable}, cv[j][4:1]);
      seq(2, {OP_WRITE_REG, REG_INPUT_SELECT, mv[j]}, r);
      check("pos", {pos_channel, pos_common, pos_temp},
            dec(mv[j][7:4]));
      check("neg", {negative_input_choice, neg_common, neg_temp},
            dec(mv[j][3:0]));
    end
    // Output bit order flips only the reply; the write still lands MSB first.
    seq(2, {OP_WRITE_REG, REG_DEVICE_CONFIG, 8'h0F}, r);
    seq(2, {OP_READ_REG, REG_INPUT_SELECT, 8'h00}, r);
    check("lsb first", r[7:0], 8'hAC);
    seq(2, {OP_WRITE_REG, REG_DEVICE_CONFIG, 8'h0E}, r);
  endtask : t_regs

  task automatic t_ram();
    logic [63:0] r;
    logic [7:0] sum;
    seq(6, {OP_SET_POINTER, 4'h0, 8'h7F, OP_WRITE_RAM, 4'h0, 8'hAA,
            OP_WRITE_RAM, 4'h0, 8'hBB}, r);
    seq(6, {OP_SET_POINTER, 4'h0, 8'h7F, OP_READ_RAM, 4'h0, 8'h00,
            OP_READ_RAM, 4'h0, 8'h00}, r);
    check("ram wrap", {r[23:16], r[7:0]}, 16'hAABB);
    seq(2, {OP_WRITE_REG, REG_CURRENT_SOURCE_2_CODE, 8'h5A}, r);
    seq(1, {OP_SAVE_BANK, 4'h1}, r);
    seq(4, {OP_SET_POINTER, 4'h0, 8'h14, OP_READ_RAM, 4'h0, 8'h00}, r);
    check("bank offset", r[7:0], 8'h5A);
    seq(2, {OP_WRITE_REG, REG_CURRENT_SOURCE_2_CODE, 8'h00}, r);
    seq(1, {OP_LOAD_BANK, 4'h1}, r);
    seq(2, {OP_READ_REG, REG_CURRENT_SOURCE_2_CODE, 8'h00}, r);
    check("bank load", r[7:0], 8'h5A);
    sum = 8'h00;
    seq(2, {OP_SET_POINTER, 4'h0, 8'h30}, r);
    for (int j = 0; j < 16; j++) begin
      seq(2, {OP_WRITE_RAM, 4'h0, 8'(8'h10 + j)}, r);
      sum += 8'(8'h10 + j);
    end
    seq(2, {OP_CHECKSUM, 4'h3, 8'h00}, r);
    check("bank sum", r[7:0], sum);
  endtask : t_ram

  task automatic pulse_conv(input logic [23:0] v);
    @(posedge mclk);
    conv_result <= v;
    conv_valid <= 1'b1;
    @(posedge mclk);
    conv_valid <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : pulse_conv

  task automatic t_conv();
    logic [63:0] r;
    pulse_conv(24'hC3A512);
    check("ready low", conversion_ready_flag_n, 1'b0);
    pulse_conv(24'h3C5AE1);
    seq(4, {OP_READ_DATA, OP_READ_DATA_LO, 24'h0}, r);
    check("result", r[23:0], 24'h3C5AE1);
    check("ready high", conversion_ready_flag_n, 1'b1);
  endtask : t_conv

  task automatic t_sync();
    logic [63:0] r;
    @(posedge mclk);
    conversion_sync_pin_n <= 1'b0;
    repeat (12) @(posedge mclk);
    check("mod held", modulator_reset, 1'b1);
    conversion_sync_pin_n <= 1'b1;
    repeat (12) @(posedge mclk);
    check("mod free", modulator_reset, 1'b0);
    seq(1, {OP_SYNC, OP_SYNC_LO}, r);
    check("sync command", both_hits, 1);
  endtask : t_sync

  task automatic tally_and_finish();
    if (errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // Reset four cycles, then the scenarios; the RAM run uses the other sense.
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    clock_sense_select = 1'b1;
    conversion_sync_pin_n = 1'b1;
    conv_valid = 1'b0;
    conv_result = 24'h0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_regs();
    clock_sense_select <= 1'b0;
    t_ram();
    t_conv();
    t_sync();
    tally_and_finish();
  end
endmodule : test_adc_config_bank_serial_ctrl

`default_nettype wire
